// ==== design/removable_memory_transfer_ctrl.v ====
/*
 * Cartridge status, transfer command and program size words, reached
 * over AXI4-Lite, plus a sticky interrupt status with mask.
 * Byte map: status 0x34, control 0x38, sizes 0x3C, interrupt status
 * 0x40 (write one to clear), interrupt mask 0x44; other words answer
 * with a slave error, read zero and ignore writes.
 * A write is answered two cycles after the later of its address and
 * data is taken; a read one cycle after its address is taken.
 * All state, the bus handshakes included, holds while ce is low.
 * Assumes an outside engine performs the actual copy or compare once
 * op_start pulses, and answers with a one-cycle op_done; op_mismatch
 * is looked at only with op_done of a compare.
 * Assumes cartridge pins and size codes are synchronous to aclk and
 * that cart_detect is valid on the first enabled edge after reset.
 */
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "cart_xfer_defines.vh"

module removable_memory_transfer_ctrl (
    input wire aclk, // System clock, 200 MHz
    input wire aresetn, // Synchronous reset, active low
    input wire ce, // Clock enable, freezes all state when low
    input wire [7:0] s_axi_awaddr, // Write address
    input wire s_axi_awvalid, // Write address valid
    output wire s_axi_awready, // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Write byte strobes
    input wire s_axi_wvalid, // Write data valid
    output wire s_axi_wready, // Write data ready
    output reg [1:0] s_axi_bresp, // Write response
    output reg s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire [7:0] s_axi_araddr, // Read address
    input wire s_axi_arvalid, // Read address valid
    output wire s_axi_arready, // Read address ready
    output reg [31:0] s_axi_rdata, // Read data
    output reg [1:0] s_axi_rresp, // Read response
    output reg s_axi_rvalid, // Read data valid
    input wire s_axi_rready, // Read data ready
    input wire cart_detect, // Cartridge sensed in its slot
    input wire cart_has_clock, // Installed cartridge carries a clock
    input wire cart_write_protect, // Protect switch engaged
    input wire [3:0] cart_type, // Cartridge type code
    input wire [7:0] cart_prog_size, // Cartridge program size code
    input wire [7:0] cpu_prog_size, // CPU program size code
    input wire edit_mode, // Controller in its editing mode
    output reg op_start, // One-cycle start to transfer engine
    output reg [2:0] op_kind, // One-hot: save, load, compare
    input wire op_done, // Engine finished, one-cycle pulse
    input wire op_mismatch, // With op_done: difference or no compare
    output wire irq // Level interrupt
);

    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_CHECK = 3'b010;
    localparam [2:0] S_RUN = 3'b100;

    // Refusal reason codes
    localparam [3:0] RF_EDIT = 4'h1;
    localparam [3:0] RF_WP = 4'h2;
    localparam [3:0] RF_CAP = 4'h4;
    localparam [3:0] RF_NOPROG = 4'h8;

    // Register select bits
    localparam SEL_STATUS = 0;
    localparam SEL_CTRL = 1;
    localparam SEL_SIZE = 2;
    localparam SEL_IRQ_ST = 3;
    localparam SEL_IRQ_MASK = 4;

    reg [2:0] state_q;
    reg [2:0] cmd_q;
    reg result_q;
    reg [3:0] err_q;
    reg present_q;
    reg pwrup_done_q;
    reg [`IRQ_NUM-1:0] irq_status_q;
    reg [`IRQ_NUM-1:0] irq_mask_q;
    reg aw_full_q;
    reg w_full_q;
    reg [5:0] aw_idx_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg [`IRQ_NUM-1:0] irq_event;
    reg [3:0] refuse;
    reg [15:0] status_word;
    reg [15:0] ctrl_word;
    reg [31:0] rdata_d;
    reg [1:0] rresp_d;

    // Capacity of the cartridge as a program size code
    function [7:0] cart_capacity;
        input [3:0] t;
        begin
            case (t)
                `TYPE_EE4K: cart_capacity = `SIZE_4;
                `TYPE_EE8K: cart_capacity = `SIZE_8;
                `TYPE_FL16K: cart_capacity = `SIZE_16;
                default: cart_capacity = `SIZE_NONE;
            endcase
        end
    endfunction

    // Lowest set command bit wins if software sets several
    function [2:0] pick_cmd;
        input [2:0] c;
        begin
            if (c[`CT_SAVE]) begin
                pick_cmd = 3'b001;
            end else if (c[`CT_LOAD]) begin
                pick_cmd = 3'b010;
            end else if (c[`CT_COMPARE]) begin
                pick_cmd = 3'b100;
            end else begin
                pick_cmd = 3'b000;
            end
        end
    endfunction

    // Word select from a word index, shared by the write and read paths
    function [4:0] reg_sel;
        input [5:0] idx;
        begin
            case (idx)
                `IDX_CART_STATUS: reg_sel = 5'h01;
                `IDX_XFER_CTRL: reg_sel = 5'h02;
                `IDX_PROG_SIZE: reg_sel = 5'h04;
                `IDX_IRQ_STATUS: reg_sel = 5'h08;
                `IDX_IRQ_MASK: reg_sel = 5'h10;
                default: reg_sel = 5'h00;
            endcase
        end
    endfunction

    wire protect_eff = (cart_write_protect && cart_type != `TYPE_NONE) ||
        (cart_type == `TYPE_EPROM);
    wire [7:0] cart_cap = cart_capacity(cart_type);
    wire [15:0] size_word = {cpu_prog_size, cart_prog_size};

    // Unused bits stay at the zero given first
    always @* begin
        status_word = 16'h0000;
        status_word[`ST_PRESENT] = present_q;
        status_word[`ST_CLOCK] = cart_has_clock;
        status_word[`ST_PROTECT] = protect_eff;
        status_word[`ST_TYPE_LO +: 4] = cart_type;
    end

    always @* begin
        ctrl_word = 16'h0000;
        ctrl_word[`CT_SAVE] = cmd_q[`CT_SAVE];
        ctrl_word[`CT_LOAD] = cmd_q[`CT_LOAD];
        ctrl_word[`CT_COMPARE] = cmd_q[`CT_COMPARE];
        ctrl_word[`CT_RESULT] = result_q;
        ctrl_word[`CT_ERR_EDIT +: 4] = err_q;
    end

    // AXI write path
    // Address and data are held apart until both are in, in either order
    assign s_axi_awready = ce && !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready = ce && !w_full_q && !s_axi_bvalid;
    wire wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
    wire wr_low = wr_fire && wstrb_q[0];
    wire [4:0] wr_sel = reg_sel(aw_idx_q);
    wire wr_ctrl = wr_low && wr_sel[SEL_CTRL];
    wire wr_irq_st = wr_low && wr_sel[SEL_IRQ_ST];
    wire wr_irq_mask = wr_low && wr_sel[SEL_IRQ_MASK];
    wire wr_mapped = |wr_sel;
    wire [2:0] new_cmd = pick_cmd(wdata_q[2:0]);
    wire cmd_accept = wr_ctrl && new_cmd != 3'b000;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_idx_q <= 6'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr[7:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI read path, data registered
    assign s_axi_arready = ce && !s_axi_rvalid;
    wire [4:0] rd_sel = reg_sel(s_axi_araddr[7:2]);

    always @* begin
        rdata_d = 32'h0000_0000;
        rresp_d = `RESP_OKAY;
        case (rd_sel)
            5'h01: rdata_d = {16'h0000, status_word};
            5'h02: rdata_d = {16'h0000, ctrl_word};
            5'h04: rdata_d = {16'h0000, size_word};
            5'h08: rdata_d[`IRQ_NUM-1:0] = irq_status_q;
            5'h10: rdata_d[`IRQ_NUM-1:0] = irq_mask_q;
            default: rresp_d = `RESP_SLVERR;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= rresp_d;
                s_axi_rdata <= rdata_d;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Presence is caught once, on the first enabled edge after reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            present_q <= 1'b0;
            pwrup_done_q <= 1'b0;
        end else if (ce && !pwrup_done_q) begin
            present_q <= cart_detect;
            pwrup_done_q <= 1'b1;
        end
    end

    // Refusal reasons, one-hot in error field order: edit, wp, cap, noprog
    always @* begin
        refuse = 4'h0;
        if (edit_mode) begin
            refuse = RF_EDIT;
        end else if (cmd_q[`CT_SAVE]) begin
            if (protect_eff) begin
                refuse = RF_WP;
            end else if (cpu_prog_size > cart_cap) begin
                refuse = RF_CAP;
            end
        end else if (cmd_q[`CT_LOAD]) begin
            if (cart_prog_size == `SIZE_NONE) begin
                refuse = RF_NOPROG;
            end else if (cart_prog_size > `CPU_CAP_CODE) begin
                refuse = RF_CAP;
            end
        end else if (cmd_q[`CT_COMPARE]) begin
            if (cart_prog_size == `SIZE_NONE) begin
                refuse = RF_NOPROG;
            end
        end
    end

    // Command sequencer
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= S_IDLE;
            cmd_q <= 3'b000;
            result_q <= 1'b0;
            err_q <= 4'h0;
            op_start <= 1'b0;
            op_kind <= 3'b000;
        end else if (ce) begin
            op_start <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    // Writes while busy are dropped; software waits for clear
                    if (cmd_accept) begin
                        cmd_q <= new_cmd;
                        err_q <= 4'h0;
                        state_q <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    if (refuse != 4'h0) begin
                        err_q <= refuse;
                        if (cmd_q[`CT_COMPARE]) begin
                            result_q <= 1'b1;
                        end
                        cmd_q <= 3'b000;
                        state_q <= S_IDLE;
                    end else begin
                        op_start <= 1'b1;
                        op_kind <= cmd_q;
                        state_q <= S_RUN;
                    end
                end
                S_RUN: begin
                    // A done pulse while ce is low is lost
                    if (op_done) begin
                        if (cmd_q[`CT_COMPARE]) begin
                            result_q <= op_mismatch;
                        end
                        cmd_q <= 3'b000;
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                    cmd_q <= 3'b000;
                end
            endcase
        end
    end

    // Events that set the sticky interrupt bits
    always @* begin
        irq_event = {`IRQ_NUM{1'b0}};
        irq_event[`IRQ_DONE] = state_q == S_RUN && op_done;
        irq_event[`IRQ_REFUSED] = state_q == S_CHECK && refuse != 4'h0;
    end

    // Sticky status, set wins over write-one-to-clear
    genvar gi;
    generate
        for (gi = 0; gi < `IRQ_NUM; gi = gi + 1) begin : g_irq
            always @(posedge aclk) begin
                if (!aresetn) begin
                    irq_status_q[gi] <= 1'b0;
                    irq_mask_q[gi] <= 1'b0;
                end else if (ce) begin
                    if (irq_event[gi]) begin
                        irq_status_q[gi] <= 1'b1;
                    end else if (wr_irq_st && wdata_q[gi]) begin
                        irq_status_q[gi] <= 1'b0;
                    end
                    if (wr_irq_mask) begin
                        irq_mask_q[gi] <= wdata_q[gi];
                    end
                end
            end
        end
    endgenerate

    // Level output, high until software clears or masks the cause
    assign irq = |(irq_status_q & irq_mask_q);

endmodule

// ==== design/cart_xfer_defines.vh ====
/*
 * Constants for the cartridge transfer controller: register indices,
 * byte addresses, field positions, type, size and response codes.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef CART_XFER_DEFINES_VH
`define CART_XFER_DEFINES_VH

// Word indices within the auxiliary word area
`define IDX_CART_STATUS 6'h0d
`define IDX_XFER_CTRL 6'h0e
`define IDX_PROG_SIZE 6'h0f
`define IDX_IRQ_STATUS 6'h10
`define IDX_IRQ_MASK 6'h11
// Byte address is four times the index
`define ADDR_CART_STATUS {`IDX_CART_STATUS, 2'b00}
`define ADDR_XFER_CTRL {`IDX_XFER_CTRL, 2'b00}
`define ADDR_PROG_SIZE {`IDX_PROG_SIZE, 2'b00}
`define ADDR_IRQ_STATUS {`IDX_IRQ_STATUS, 2'b00}
`define ADDR_IRQ_MASK {`IDX_IRQ_MASK, 2'b00}

// Status word fields
`define ST_PRESENT 0
`define ST_CLOCK 1
`define ST_PROTECT 2
`define ST_TYPE_LO 4

// Control word fields
`define CT_SAVE 0
`define CT_LOAD 1
`define CT_COMPARE 2
`define CT_RESULT 3
`define CT_ERR_EDIT 12
`define CT_ERR_WP 13
`define CT_ERR_CAP 14
`define CT_ERR_NOPROG 15

// Cartridge type codes
`define TYPE_NONE 4'h0
`define TYPE_EE4K 4'h1
`define TYPE_EE8K 4'h2
`define TYPE_FL16K 4'h3
`define TYPE_EPROM 4'h4

// Program size codes, two BCD digits
`define SIZE_NONE 8'h00
`define SIZE_4 8'h04
`define SIZE_8 8'h08
`define SIZE_16 8'h16
`define CPU_CAP_CODE 8'h16

// Interrupt bits
`define IRQ_DONE 0
`define IRQ_REFUSED 1
`define IRQ_NUM 2

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== bench/cart_engine_model.sv ====
/* Transfer engine model beside the controller.
   Assumes one request at a time; the bench picks delay and outcome. */
`timescale 1ns/1ps
module cart_engine_model (
    input wire aclk, // Clock
    input wire aresetn, // Reset, active low
    input wire op_start, // Start pulse
    input wire mis_cfg, // Compare outcome to give
    input wire slow, // Long answer delay
    output reg op_done, // Finish pulse
    output wire op_mismatch // Valid with op_done only
);
reg busy_q;
reg [4:0] cnt_q;
// Wrong value outside the done pulse, so a stray sample shows
assign op_mismatch = op_done ? mis_cfg : ~mis_cfg;
always @(posedge aclk) begin
    op_done <= 1'b0;
    if (!aresetn) begin
        busy_q <= 1'b0;
    end else if (op_start) begin
        busy_q <= 1'b1;
        cnt_q <= slow ? 5'h14 : 5'h00;
    end else if (busy_q && cnt_q == 5'h00) begin
        busy_q <= 1'b0;
        op_done <= 1'b1;
    end else begin
        cnt_q <= cnt_q - 5'h01;
    end
end
endmodule

// ==== bench/xfer_checker.sv ====
/* Bus and engine handshake properties of the transfer controller.
   Assumes it is bound to the controller top. */
`timescale 1ns/1ps
module xfer_checker (
    input wire aclk, // Clock
    input wire aresetn, // Reset, active low
    input wire ce, // Enable
    input wire [7:0] s_axi_awaddr, // AW address
    input wire s_axi_awvalid, // AW valid
    input wire s_axi_awready, // AW ready
    input wire s_axi_wvalid, // W valid
    input wire s_axi_wready, // W ready
    input wire s_axi_bvalid, // B valid
    input wire s_axi_arvalid, // AR valid
    input wire s_axi_arready, // AR ready
    input wire s_axi_rvalid, // R valid
    input wire s_axi_rready, // R ready
    input wire edit_mode, // Edit mode
    input wire op_start, // Start pulse
    input wire [2:0] op_kind // Kind
);
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
sequence no_start;
    !op_start ##1 !op_start ##1 !op_start;
endsequence
chk_ready_gated: assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("ready high while disabled");
chk_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
chk_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
chk_b_answer: assert property (wr_taken |=> ##1 s_axi_bvalid)
    else $error("write response late");
chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
chk_r_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
chk_start_pulse: assert property (op_start |=> !op_start)
    else $error("start longer than one cycle");
chk_kind_onehot: assert property (op_start |-> $onehot(op_kind))
    else $error("kind not one-hot");
chk_edit_refuse: assert property ((wr_taken ##0 edit_mode && s_axi_awaddr == 8'h38) |=> no_start)
    else $error("start during edit mode");
endmodule
bind removable_memory_transfer_ctrl xfer_checker u_xfer_checker (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .edit_mode(edit_mode),
    .op_start(op_start), .op_kind(op_kind));

// ==== bench/testbench.sv ====
/* Register-level bench for the transfer controller.
   Assumes the engine model answers starts; bready and rready stay high. */
`timescale 1ns/1ps
module testbench;
reg aclk = 0, aresetn = 0, ce = 1, awvalid = 0, wvalid = 0, arvalid = 0;
reg [7:0] awaddr = 0, araddr = 0, csz = 8'h08, psz = 8'h04;
reg [31:0] wdata = 0;
reg det = 1, hclk = 1, wp = 0, edit = 0, mis = 0, slow = 0;
reg [3:0] ctype = 4'h2;
wire awready, wready, bvalid, arready, rvalid, op_start, op_done, op_mismatch, irq;
wire [1:0] bresp, rresp;
wire [31:0] rdata;
wire [2:0] op_kind;
reg [31:0] d;
reg [1:0] r;
reg [2:0] kind_q;
integer fails = 0, n_compared = 0, i;
removable_memory_transfer_ctrl u_removable_memory_transfer_ctrl (.aclk(aclk),
    .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .cart_detect(det), .cart_has_clock(hclk), .cart_write_protect(wp), .cart_type(ctype),
    .cart_prog_size(csz), .cpu_prog_size(psz), .edit_mode(edit), .op_start(op_start),
    .op_kind(op_kind), .op_done(op_done), .op_mismatch(op_mismatch), .irq(irq));
cart_engine_model u_cart_engine_model (.aclk(aclk), .aresetn(aresetn), .op_start(op_start),
    .mis_cfg(mis), .slow(slow), .op_done(op_done), .op_mismatch(op_mismatch));
initial forever #2.5 aclk = ~aclk;
always @(posedge aclk) if (op_start) kind_q <= op_kind;
task give_verdict; begin
    $display("compared %0d, mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
end endtask
task check(input [8*6-1:0] nm, input [31:0] e, input [31:0] g); begin
    n_compared = n_compared + 1;
    if (g !== e) begin
        fails = fails + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, e, g);
    end
end endtask
// Handshakes judged at the falling edge, where nothing is moving
task wr(input [7:0] a, input [15:0] v); reg sa, sw, b; integer n; begin
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    b = 0;
    for (n = 0; n < 100 && !b; n = n + 1) begin
        @(negedge aclk);
        sa = awvalid & awready;
        sw = wvalid & wready;
        b = bvalid;
        r = bresp;
        @(posedge aclk);
        if (sa) awvalid <= 1'b0;
        if (sw) wvalid <= 1'b0;
    end
    check("bvalid", 32'h0000_0001, {31'h0000_0000, b});
end endtask
task rd(input [7:0] a); reg s, g; integer n; begin
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    g = 0;
    for (n = 0; n < 100 && !g; n = n + 1) begin
        @(negedge aclk);
        s = arvalid & arready;
        g = rvalid;
        d = rdata;
        r = rresp;
        @(posedge aclk);
        if (s) arvalid <= 1'b0;
    end
    check("rvalid", 32'h0000_0001, {31'h0000_0000, g});
end endtask
task cmd(input [2:0] c, k, input [15:0] e, input [3:0] t, input [7:0] cs, ps,
    input [3:0] f); integer n; begin
    @(posedge aclk);
    {edit, wp, mis, slow} <= f;
    ctype <= t;
    csz <= cs;
    psz <= ps;
    wr(8'h38, {13'h0000, c});
    if (k != 3'h0 && f[0]) begin
        rd(8'h38);
        check("busy", {29'h0000_0000, k}, d);
    end
    for (n = 0; n < 100 && irq !== 1'b1; n = n + 1) @(negedge aclk);
    check("irqwt", 32'h0000_0001, {31'h0000_0000, irq});
    rd(8'h38);
    check("ctrl", {16'h0000, e}, d);
    if (k != 3'h0) check("kind", {29'h0000_0000, k}, {29'h0000_0000, kind_q});
    wr(8'h40, 16'h0003);
    $display("test command %h done", c);
end endtask
initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    ce <= 1'b0;
    repeat (3) @(posedge aclk);
    ce <= 1'b1;
    wr(8'h44, 16'h0003);
    rd(8'h34);
    check("status", 32'h0000_0023, d);
    det <= 1'b0;
    hclk <= 1'b0;
    wp <= 1'b1;
    for (i = 0; i < 5; i = i + 1) begin
        ctype <= i[3:0];
        rd(8'h34);
        check("status", {24'h00_0000, i[3:0], 1'b0, i != 0, 2'b01}, d);
    end
    $display("test status done");
    rd(8'h3c);
    check("sizes", 32'h0000_0408, d);
    wr(8'h3c, 16'hffff);
    wr(8'h34, 16'hffff);
    rd(8'h3c);
    check("sizes", 32'h0000_0408, d);
    wr(8'h60, 16'hffff);
    check("bresp", 32'h0000_0002, {30'h0000_0000, r});
    rd(8'h60);
    check("rresp", 32'h0000_0002, {30'h0000_0000, r});
    check("rdata", 32'h0000_0000, d);
    $display("test map done");
    cmd(3'h1, 3'h1, 16'h0000, 4'h2, 8'h08, 8'h04, 4'h1);
    cmd(3'h6, 3'h2, 16'h0000, 4'h2, 8'h08, 8'h04, 4'h0);
    cmd(3'h4, 3'h4, 16'h0008, 4'h2, 8'h08, 8'h04, 4'h3);
    cmd(3'h4, 3'h4, 16'h0000, 4'h2, 8'h08, 8'h04, 4'h0);
    cmd(3'h1, 3'h0, 16'h1000, 4'h2, 8'h08, 8'h04, 4'h8);
    cmd(3'h1, 3'h0, 16'h2000, 4'h2, 8'h08, 8'h04, 4'h4);
    cmd(3'h1, 3'h0, 16'h2000, 4'h4, 8'h08, 8'h04, 4'h0);
    cmd(3'h1, 3'h0, 16'h4000, 4'h1, 8'h08, 8'h08, 4'h0);
    cmd(3'h2, 3'h0, 16'h8000, 4'h2, 8'h00, 8'h04, 4'h0);
    cmd(3'h4, 3'h0, 16'h8008, 4'h2, 8'h00, 8'h04, 4'h0);
    cmd(3'h1, 3'h0, 16'h1008, 4'h2, 8'h08, 8'h04, 4'h8);
    wr(8'h38, 16'h0001);
    rd(8'h40);
    check("irqst", 32'h0000_0002, d);
    @(negedge aclk);
    check("irq", 32'h0000_0001, {31'h0000_0000, irq});
    wr(8'h44, 16'h0001);
    @(negedge aclk);
    check("irq", 32'h0000_0000, {31'h0000_0000, irq});
    wr(8'h44, 16'h0003);
    wr(8'h40, 16'h0001);
    @(negedge aclk);
    check("irq", 32'h0000_0001, {31'h0000_0000, irq});
    wr(8'h40, 16'h0002);
    @(negedge aclk);
    check("irq", 32'h0000_0000, {31'h0000_0000, irq});
    $display("test interrupt done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h34);
    check("status", 32'h0000_0020, d);
    rd(8'h38);
    check("ctrl", 32'h0000_0000, d);
    $display("test reset done");
    give_verdict;
end
initial begin
    #100000;
    fails = fails + 1;
    give_verdict;
end
endmodule
